//--- logic/gauge_consts.svh
// Purpose: Constants of the charge-accounting core
// Assumes: Sense voltage in signed microvolts, temperature in 10 C steps
// Notes: Definitions only
`ifndef GAUGE_CONSTS_SVH
`define GAUGE_CONSTS_SVH

// ----------------------------------------
// Initial full counts by strap setting
// ----------------------------------------
`define FULL_HIGH_P1HI 16'h9d00
`define FULL_FLOAT_P1HI 16'h7e00
`define FULL_LOW_P1HI 16'h7100
`define FULL_HIGH_P1LO 16'h6500
`define FULL_FLOAT_P1LO 16'h8c00
`define FULL_LOW_P1LO 16'h5b00

// ----------------------------------------
// Sense thresholds, microvolts
// ----------------------------------------
`define CHARGE_LIMIT_UV 16'shfe70
`define DISCHARGE_LIMIT_UV 16'sh01f4
`define FAST_DISCHARGE_UV 16'sh07d0
`define FAST_CHARGE_UV 16'shf830

// ----------------------------------------
// Counts and limits
// ----------------------------------------
`define VALID_CHARGE_COUNTS 16'h0100
`define SELF_DISCHARGE_LIMIT 16'h1000
`define COUNT_MAX 16'hffff
`define FAST_RATE_COUNTS 16'h0002
`define FREEZE_STEP 4'h4
`define SD_BASE_STEP 4'h4
`define SD_MAX_SHIFT 3'h7
`define WARM_STEP 4'h7
`define HOT_STEP 4'h9
`define SD_DAY_THRESHOLD 32'h01a5e000

// ----------------------------------------
// Compensation factors, percent
// ----------------------------------------
`define TRICKLE_NOMINAL 7'h50
`define FAST_NOMINAL 7'h5f
`define TRICKLE_WARM 7'h4b
`define FAST_WARM 7'h5a
`define TRICKLE_HOT 7'h46
`define FAST_HOT 7'h55
`define DISCHARGE_FACTOR 7'h64
`define PERCENT_FULL 32'h00000064

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define SECOND_NS 1000000000
`define DISPLAY_HOLD_S 4'ha

`endif

//--- logic/gauge_pkg.sv
// Purpose: Types of the charge-accounting core
// Assumes: Used with gauge_consts.svh
// Notes: Straps are three-level pins
package gauge_pkg;

  // Three-level strap reading
  typedef enum logic [1:0] {
    strap_low = 2'b00,
    strap_float = 2'b01,
    strap_high = 2'b10
  } strap_level_type;

  // Gauge state shown to the outside
  typedef struct packed {
    logic [15:0] available_charge_count;
    logic [15:0] discharge_counter;
    logic [15:0] learned_capacity;
    logic valid_discharge_flag;
    logic charge_valid;
    logic fast_charge;
    logic display_active;
  } gauge_status_type;

endpackage : gauge_pkg

//--- logic/battery_charge_accounting.sv
// Purpose: Charge, discharge and self-discharge accounting of a gas gauge
// Assumes: One sense sample per sense_valid_in pulse, inputs synchronous
// Notes: Count scaling per sample is a parameter
// Operation
// - Available charge rises to learned capacity, falls to zero, never below.
// - Available charge clears at init unless program strap four is low, and at first valid charge after empty.
// - No available-charge increments once it equals learned capacity.
// - Initial full count chosen from full-count strap and program strap one.
// - Program strap four low at reset loads capacity, disables self-discharge.
// - Discharge counter counts self-discharge only while available charge nonzero.
// - Discharge counter clears at full, saturates at all ones.
// - First valid charge after qualified empty copies discharge counter to capacity.
// - More than 4096 self-discharge counts disqualifies capacity transfer.
// - Temperature below zero at empty disqualifies capacity transfer.
// - Valid-discharge flag shows whether present discharge still qualifies.
// - Charge valid after 256 counts below -400 uV, continues until above.
// - Charge rate proportional to compensated voltage; display below -2 mV.
// - Above 500 uV every count decrements charge, increments discharge counter.
// - Above 2 mV display on, held ten seconds after dropping.
// - Self-discharge unless disabled, nominal charge/80 per day at 20-30 C.
// - Self-discharge rate doubles every 10 C step, /320 up to /2.5.
// - Fast charge at two counts per second; fast factor until rate known.
// - Charge efficiency chosen by temperature band and charge rate.
// - Discharge factor is exactly one.
// - No counting between -400 and +500 uV.
// - Learned capacity equals initial full count at init.
// - Corrupted data clears available charge, reloads capacity.
`timescale 1ns/1ps
`default_nettype none
`include "gauge_consts.svh"

module battery_charge_accounting
  import gauge_pkg::*;
#(
  parameter int unsigned CYCLES_PER_SECOND = `SECOND_NS / `CLK_PERIOD_NS,
  parameter int unsigned UV_SAMPLES_PER_COUNT = 100000
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Measurement front end
  input wire logic sense_valid_in,
  input wire logic signed [15:0] offset_corrected_sense_voltage_in,
  input wire logic [3:0] temperature_step_in,
  input wire logic end_of_discharge_threshold_in,
  input wire logic data_corrupt_in,
  // Straps and display enable
  input wire strap_level_type full_count_strap_in,
  input wire strap_level_type program_strap_1_in,
  input wire strap_level_type program_strap_4_in,
  input wire logic display_enable_in,
  // Gauge state
  output gauge_status_type status_out,
  output logic [15:0] initial_full_count_out
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Full count lookup from the straps
  function automatic logic [15:0] full_count(input strap_level_type s, input strap_level_type p1);
    logic p1_low;
    p1_low = (p1 == strap_low);
    if (s == strap_high) begin
      full_count = p1_low ? `FULL_HIGH_P1LO : `FULL_HIGH_P1HI;
    end else if (s == strap_float) begin
      full_count = p1_low ? `FULL_FLOAT_P1LO : `FULL_FLOAT_P1HI;
    end else begin
      full_count = p1_low ? `FULL_LOW_P1LO : `FULL_LOW_P1HI;
    end
  endfunction : full_count

  // Saturating increment, used for several counters
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == `COUNT_MAX) ? v : v + 16'h0001;
  endfunction : sat_inc

  localparam logic [31:0] COUNT_UNIT = 32'(UV_SAMPLES_PER_COUNT) * `PERCENT_FULL;

  logic [15:0] charge_left;
  logic [15:0] spent_count;
  logic [15:0] capacity;
  logic qualified;
  logic sd_disable;
  logic [15:0] full_start;
  logic [31:0] sec_cnt;
  logic sec_tick;
  logic charging;
  logic discharging;
  logic in_charge;
  logic in_discharge;
  logic acc_dir;
  logic [31:0] acc;
  logic charge_tick;
  logic discharge_tick;
  logic sd_tick;
  logic [31:0] sd_acc;
  logic [15:0] chg_run;
  logic charge_valid;
  logic valid_charge_start;
  logic [15:0] chg_in_sec;
  logic fast;
  logic rate_known;
  logic empty_q;
  logic empty_pending;
  logic [15:0] sd_since_full;
  logic fast_dis_cond;
  logic fast_chg_cond;
  logic [3:0] hold;
  logic display_active;
  logic [6:0] factor;
  logic [16:0] mag;
  logic [31:0] prod;
  logic [31:0] sum;
  logic [2:0] sd_shift;
  logic [31:0] sd_sum;
  logic [15:0] next_charge_left;
  logic [15:0] next_spent_count;

  assign full_start = full_count(full_count_strap_in, program_strap_1_in);

  // ----------------------------------------
  // Sample classification and compensation
  // ----------------------------------------

  // dead band between the two limits
  assign in_charge = offset_corrected_sense_voltage_in < `CHARGE_LIMIT_UV;
  assign in_discharge = offset_corrected_sense_voltage_in > `DISCHARGE_LIMIT_UV;
  assign mag = in_charge ? 17'(-offset_corrected_sense_voltage_in)
                         : 17'(offset_corrected_sense_voltage_in);

  always_comb begin
    logic use_fast;
    use_fast = fast || !rate_known;
    if (!in_charge) begin
      factor = `DISCHARGE_FACTOR;
    end else if (temperature_step_in >= `HOT_STEP) begin
      factor = use_fast ? `FAST_HOT : `TRICKLE_HOT;
    end else if (temperature_step_in >= `WARM_STEP) begin
      factor = use_fast ? `FAST_WARM : `TRICKLE_WARM;
    end else begin
      factor = use_fast ? `FAST_NOMINAL : `TRICKLE_NOMINAL;
    end
  end

  assign prod = 32'(mag) * 32'(factor);
  // Direction change restarts the fraction, but the sample itself still counts
  assign sum = ((acc_dir != in_charge) ? 32'h00000000 : acc) + prod;

  // ----------------------------------------
  // One-second time base
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || sec_cnt == CYCLES_PER_SECOND - 1) begin
      sec_cnt <= 32'h00000000;
    end else begin
      sec_cnt <= sec_cnt + 32'h00000001;
    end
  end
  assign sec_tick = (sec_cnt == CYCLES_PER_SECOND - 1);

  // count rate proportional to compensated voltage
  always_ff @(posedge clk_sys_in) begin
    charge_tick <= 1'b0;
    discharge_tick <= 1'b0;
    if (!rst_n_in) begin
      acc <= 32'h00000000;
      acc_dir <= 1'b0;
    end else if (sense_valid_in) begin
      acc_dir <= in_charge;
      if (!in_charge && !in_discharge) begin
        acc <= 32'h00000000;
      end else if (sum >= COUNT_UNIT) begin
        acc <= sum - COUNT_UNIT;
        charge_tick <= in_charge;
        discharge_tick <= in_discharge;
      end else begin
        acc <= sum;
      end
    end
  end

  // Direction seen on the latest sample
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      charging <= 1'b0;
      discharging <= 1'b0;
    end else if (sense_valid_in) begin
      charging <= in_charge;
      discharging <= in_discharge;
    end
  end

  // ----------------------------------------
  // Charge qualification and rate
  // ----------------------------------------

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || (sense_valid_in && !in_charge)) begin
      chg_run <= 16'h0000;
      charge_valid <= 1'b0;
    end else if (charge_tick) begin
      chg_run <= sat_inc(chg_run);
      if (chg_run == `VALID_CHARGE_COUNTS) begin
        charge_valid <= 1'b1;
      end
    end
  end
  assign valid_charge_start = charge_tick && chg_run == `VALID_CHARGE_COUNTS;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || !charging) begin
      chg_in_sec <= 16'h0000;
      fast <= 1'b1;
      rate_known <= 1'b0;
    end else if (sec_tick) begin
      chg_in_sec <= 16'h0000;
      fast <= chg_in_sec >= `FAST_RATE_COUNTS;
      rate_known <= 1'b1;
    end else if (charge_tick) begin
      chg_in_sec <= sat_inc(chg_in_sec);
    end
  end

  // ----------------------------------------
  // Self-discharge estimate
  // ----------------------------------------

  assign sd_shift = (temperature_step_in <= `SD_BASE_STEP) ? 3'h0 :
                    (temperature_step_in - `SD_BASE_STEP > 4'(`SD_MAX_SHIFT)) ? `SD_MAX_SHIFT :
                    3'(temperature_step_in - `SD_BASE_STEP);
  assign sd_sum = sd_acc + ({16'h0000, charge_left} << sd_shift);

  always_ff @(posedge clk_sys_in) begin
    sd_tick <= 1'b0;
    if (!rst_n_in || sd_disable || charge_left == 16'h0000) begin
      sd_acc <= 32'h00000000;
    end else if (sec_tick) begin
      if (sd_sum >= `SD_DAY_THRESHOLD) begin
        sd_acc <= sd_sum - `SD_DAY_THRESHOLD;
        sd_tick <= 1'b1;
      end else begin
        sd_acc <= sd_sum;
      end
    end
  end

  // ----------------------------------------
  // Counter updates
  // ----------------------------------------
  always_comb begin
    next_charge_left = charge_left;
    if (charge_tick && charge_left < capacity) begin
      next_charge_left = charge_left + 16'h0001;
    end
    if (discharge_tick && next_charge_left != 16'h0000) begin
      next_charge_left = next_charge_left - 16'h0001;
    end
    if (sd_tick && next_charge_left != 16'h0000) begin
      next_charge_left = next_charge_left - 16'h0001;
    end
    next_spent_count = discharge_tick ? sat_inc(spent_count) : spent_count;
    if (sd_tick && charge_left != 16'h0000) begin
      next_spent_count = sat_inc(next_spent_count);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      capacity <= full_start;
      charge_left <= (program_strap_4_in == strap_low) ? full_start : 16'h0000;
      sd_disable <= (program_strap_4_in == strap_low);
      spent_count <= 16'h0000;
      initial_full_count_out <= full_start;
    end else if (data_corrupt_in) begin
      charge_left <= 16'h0000;
      capacity <= full_start;
      spent_count <= 16'h0000;
    end else if (valid_charge_start && empty_pending) begin
      charge_left <= 16'h0000;
      if (qualified) begin
        capacity <= spent_count;
      end
      spent_count <= 16'h0000;
    end else begin
      charge_left <= next_charge_left;
      spent_count <= (next_charge_left == capacity) ? 16'h0000 : next_spent_count;
    end
  end

  // ----------------------------------------
  // Discharge qualification
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      empty_q <= 1'b0;
      empty_pending <= 1'b0;
    end else begin
      empty_q <= end_of_discharge_threshold_in;
      if (end_of_discharge_threshold_in && !empty_q) begin
        empty_pending <= 1'b1;
      end else if (valid_charge_start || data_corrupt_in) begin
        empty_pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || charge_left == capacity) begin
      sd_since_full <= 16'h0000;
    end else if (sd_tick) begin
      sd_since_full <= sat_inc(sd_since_full);
    end
  end

  // qualification flag, set at full wins unless corrupt data or a valid charge start comes in the same cycle
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || data_corrupt_in) begin
      qualified <= 1'b0;
    end else if (next_charge_left == capacity && !valid_charge_start) begin
      qualified <= 1'b1;
    end else if (valid_charge_start || sd_since_full > `SELF_DISCHARGE_LIMIT) begin
      qualified <= 1'b0;
    end else if (end_of_discharge_threshold_in && !empty_q
                 && temperature_step_in < `FREEZE_STEP) begin
      qualified <= 1'b0;
    end
  end

  // ----------------------------------------
  // Display activity
  // ----------------------------------------

  // fast discharge with ten second hold
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      fast_dis_cond <= 1'b0;
      fast_chg_cond <= 1'b0;
      hold <= 4'h0;
    end else begin
      if (sense_valid_in) begin
        fast_dis_cond <= offset_corrected_sense_voltage_in > `FAST_DISCHARGE_UV;
        fast_chg_cond <= offset_corrected_sense_voltage_in < `FAST_CHARGE_UV;
      end
      if (fast_dis_cond) begin
        hold <= `DISPLAY_HOLD_S;
      end else if (sec_tick && hold != 4'h0) begin
        hold <= hold - 4'h1;
      end
    end
  end

  // Registered so the display pin never glitches
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      display_active <= 1'b0;
    end else begin
      display_active <= display_enable_in && (fast_dis_cond || fast_chg_cond || hold != 4'h0);
    end
  end

  // Status bundle
  assign status_out = '{available_charge_count: charge_left, discharge_counter: spent_count,
                        learned_capacity: capacity, valid_discharge_flag: qualified,
                        charge_valid: charge_valid, fast_charge: fast && rate_known,
                        display_active: display_active};

endmodule : battery_charge_accounting
`default_nettype wire

//--- verification/front_end_model.sv
// Purpose: Sense front end and temperature sensor model
// Assumes: Called one ns after a rising edge
// Notes: Idle voltage bus shows the inverted last sample
`timescale 1ns/1ps
`default_nettype none
module front_end_model (
  // Clock
  input wire logic clk_sys_in,
  // Samples and temperature
  output logic sense_valid_out,
  output logic signed [15:0] sense_voltage_out,
  output logic [3:0] temperature_step_out
);
  // ----------------------------------------
  // Sample bursts
  // ----------------------------------------
  initial begin
    sense_valid_out = 1'b0;
    sense_voltage_out = 16'sh0000;
    temperature_step_out = 4'h6;
  end

  // Back to back samples; stale bus inverted so it is never trusted
  task automatic burst(input logic signed [15:0] val, input int n);
    for (int i = 0; i < n; i++) begin
      sense_valid_out = 1'b1;
      sense_voltage_out = val;
      @(posedge clk_sys_in);
      #1;
    end
    sense_valid_out = 1'b0;
    sense_voltage_out = ~val;
  endtask : burst

  // Temperature is a level
  task automatic set_temp(input logic [3:0] t);
    temperature_step_out = t;
  endtask : set_temp
endmodule : front_end_model
`default_nettype wire

//--- verification/battery_charge_accounting_assertions.sv
// Purpose: Port checks of the accounting core
// Assumes: One sample gives at least one count above the count size
// Notes: Bound to every core instance
`timescale 1ns/1ps
`default_nettype none
module charge_accounting_checker
  import gauge_pkg::*;
#(
  parameter int unsigned CYCLES_PER_SECOND = 100,
  parameter int unsigned UV_SAMPLES_PER_COUNT = 1000
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Core inputs
  input wire logic sense_valid_in,
  input wire logic signed [15:0] offset_corrected_sense_voltage_in,
  input wire logic [3:0] temperature_step_in,
  input wire logic end_of_discharge_threshold_in,
  input wire logic display_enable_in,
  // Core outputs
  input wire gauge_status_type status_out,
  input wire logic [15:0] initial_full_count_out
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic [2:0] charge_seen;
  logic [15:0] avail;
  logic [15:0] spent;
  logic [15:0] cap;
  logic signed [15:0] v;
  assign avail = status_out.available_charge_count;
  assign spent = status_out.discharge_counter;
  assign cap = status_out.learned_capacity;
  assign v = offset_corrected_sense_voltage_in;

  // Charge samples of the last three cycles; a charge count lags by two
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      charge_seen <= 3'h0;
    end else begin
      charge_seen <= {charge_seen[1:0], sense_valid_in && (v < -16'sd400)};
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  // ----------------------------------------
  // Counter, flag and display checks
  // ----------------------------------------
  // counter bounds
  chk_avail_within_cap: assert property (avail <= cap)
    else $error("available charge above capacity");
  chk_rise_needs_charge: assert property ($past(avail) == 16'h0 && avail != 16'h0
    |-> (|charge_seen))
    else $error("available charge rose without charge");
  chk_spent_only_clears: assert property (spent < $past(spent) |-> spent == 16'h0)
    else $error("discharge counter went down");
  chk_full_clears_spent: assert property (avail == cap |-> spent == 16'h0)
    else $error("discharge counter not clear at full");
  chk_discharge_lowers: assert property (sense_valid_in && v > 16'sd500 && avail > 16'h4
    && int'(v) >= UV_SAMPLES_PER_COUNT |-> ##2 avail < $past(avail))
    else $error("discharge sample did not lower charge");
  chk_capacity_source: assert property (cap != $past(cap)
    |-> cap == initial_full_count_out || cap == $past(spent))
    else $error("capacity from unexpected source");
  chk_cold_empty_drop: assert property ($rose(end_of_discharge_threshold_in)
    && temperature_step_in < 4'h4 |-> ##[1:2] !status_out.valid_discharge_flag)
    else $error("cold empty kept discharge qualified");
  chk_fast_lights: assert property (sense_valid_in && v > 16'sd2000 && display_enable_in
    ##1 display_enable_in [*2] |-> ##[0:2] status_out.display_active)
    else $error("fast discharge left display dark");

  // Main scenarios reached
  cov_transfer: cover property (cap != $past(cap) && cap != initial_full_count_out);
  cov_display: cover property ($rose(status_out.display_active));
  cov_charge: cover property ($rose(status_out.charge_valid));
endmodule : charge_accounting_checker

bind battery_charge_accounting charge_accounting_checker #(
  .CYCLES_PER_SECOND(CYCLES_PER_SECOND), .UV_SAMPLES_PER_COUNT(UV_SAMPLES_PER_COUNT)
) checker_inst (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .sense_valid_in(sense_valid_in),
  .offset_corrected_sense_voltage_in(offset_corrected_sense_voltage_in),
  .temperature_step_in(temperature_step_in), .display_enable_in(display_enable_in),
  .end_of_discharge_threshold_in(end_of_discharge_threshold_in),
  .status_out(status_out), .initial_full_count_out(initial_full_count_out)
);
`default_nettype wire

//--- verification/test_battery_charge_accounting.sv
// Purpose: Self-checking bench of the accounting core
// Assumes: Second of 100 cycles, one count per 1000 uV discharge sample
// Notes: Self-discharge kept off by strap so counts stay exact
`timescale 1ns/1ps
`default_nettype none
module test_battery_charge_accounting
  import gauge_pkg::*;
;
  // ----------------------------------------
  // Pins and bookkeeping
  // ----------------------------------------
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic eod = 1'b0;
  logic corrupt = 1'b0;
  logic disp_en = 1'b0;
  strap_level_type fc_strap = strap_float;
  strap_level_type p1 = strap_float;
  strap_level_type p4 = strap_float;
  logic sv;
  logic signed [15:0] v;
  logic [3:0] temp;
  gauge_status_type st;
  logic [15:0] full;
  logic [15:0] avail;
  logic [15:0] spent;
  logic [15:0] cap;
  int failures = 0;
  int checks = 0;
  // Strap table: full-count strap, program strap one, full count
  strap_level_type fc_tab[6] = '{strap_high, strap_float, strap_low, strap_high, strap_float,
    strap_low};
  strap_level_type p1_tab[6] = '{strap_high, strap_float, strap_high, strap_low, strap_low,
    strap_low};
  logic [15:0] full_tab[6] = '{16'd40192, 16'd32256, 16'd28928, 16'd25856, 16'd35840, 16'd23296};
  assign avail = st.available_charge_count;
  assign spent = st.discharge_counter;
  assign cap = st.learned_capacity;

  always #5 clk_sys_in = ~clk_sys_in;

  front_end_model fe (.clk_sys_in(clk_sys_in), .sense_valid_out(sv), .sense_voltage_out(v),
    .temperature_step_out(temp));
  battery_charge_accounting #(.CYCLES_PER_SECOND(100), .UV_SAMPLES_PER_COUNT(1000)) dut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .sense_valid_in(sv),
    .offset_corrected_sense_voltage_in(v), .temperature_step_in(temp),
    .end_of_discharge_threshold_in(eod), .data_corrupt_in(corrupt),
    .full_count_strap_in(fc_strap), .program_strap_1_in(p1), .program_strap_4_in(p4),
    .display_enable_in(disp_en), .status_out(st), .initial_full_count_out(full));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : step

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // Six reset edges with straps steady
  task automatic restart(input strap_level_type f, input strap_level_type a,
      input strap_level_type b);
    fc_strap = f;
    p1 = a;
    p4 = b;
    rst_n_in = 1'b0;
    step(6);
    rst_n_in = 1'b1;
    step(1);
  endtask : restart

  // Samples, then room for the two-edge count latency
  task automatic feed(input logic signed [15:0] val, input int n);
    fe.burst(val, n);
    step(3);
  endtask : feed

  task automatic pulse_eod();
    eod = 1'b1;
    step(2);
    eod = 1'b0;
  endtask : pulse_eod

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 6; i++) begin
      restart(fc_tab[i], p1_tab[i], strap_float);
      cmp("full count", full_tab[i], full);
      cmp("capacity", full_tab[i], cap);
      cmp("charge", 16'h0, avail);
    end
    restart(strap_low, strap_low, strap_low);
    cmp("preload", 16'd23296, avail);
    feed(16'sd1000, 300);
    cmp("discharged", 16'd22996, avail);
    cmp("counted", 16'd300, spent);
    feed(16'sd500, 4);
    feed(-16'sd400, 4);
    cmp("dead band", 16'd22996, avail);
    feed(-16'sd1000, 400);
    cmp("full", 16'd23296, avail);
    cmp("cleared at full", 16'h0, spent);
    cmp("qualified", 16'h1, {15'h0, st.valid_discharge_flag});
    cmp("charging", 16'h1, {15'h0, st.charge_valid});
    feed(-16'sd300, 1);
    cmp("charge ended", 16'h0, {15'h0, st.charge_valid});
    // learned capacity after full to empty
    feed(16'sd1000, 1000);
    cmp("drained", 16'd22296, avail);
    pulse_eod();
    cmp("still qualified", 16'h1, {15'h0, st.valid_discharge_flag});
    feed(-16'sd1000, 300);
    cmp("learned", 16'd1000, cap);
    cmp("restart count", 16'h0, spent);
    cmp("recount", 16'h1, {15'h0, avail < 16'd64});
    cmp("fast", 16'h1, {15'h0, st.fast_charge});
    feed(16'sd1000, 1100);
    cmp("floor", 16'h0, avail);
    cmp("past empty", 16'd1100, spent);
    feed(-16'sd1000, 1300);
    cmp("refull", 16'd1000, avail);
    feed(16'sd1000, 500);
    fe.set_temp(4'h3);
    pulse_eod();
    cmp("cold empty", 16'h0, {15'h0, st.valid_discharge_flag});
    fe.set_temp(4'h6);
    feed(-16'sd1000, 300);
    cmp("kept", 16'd1000, cap);
    corrupt = 1'b1;
    step(1);
    corrupt = 1'b0;
    step(2);
    cmp("corrupt charge", 16'h0, avail);
    cmp("corrupt capacity", 16'd23296, cap);
    disp_en = 1'b1;
    feed(16'sd3000, 1);
    cmp("fast lit", 16'h1, {15'h0, st.display_active});
    feed(16'sd0, 1);
    step(500);
    cmp("held", 16'h1, {15'h0, st.display_active});
    step(800);
    cmp("released", 16'h0, {15'h0, st.display_active});
    feed(-16'sd3000, 1);
    cmp("charge lit", 16'h1, {15'h0, st.display_active});
    disp_en = 1'b0;
    step(2);
    cmp("disabled", 16'h0, {15'h0, st.display_active});
    tally_and_finish();
  end
endmodule : test_battery_charge_accounting
`default_nettype wire
